// File: inc/uirq_pkg.sv
// Constants and types for the UART interrupt identity and line format block.
// Assumes a 32-bit APB slave port with byte addresses, one register per word.
package uirq_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_IDENT = 8'h00;
  localparam logic [7:0] OFS_LFC = 8'h04;
  localparam logic [7:0] OFS_FIFO = 8'h08;
  localparam logic [7:0] OFS_EVT_STAT = 8'h0c;
  localparam logic [7:0] OFS_EVT_MASK = 8'h10;

  // Interrupt sources, in falling priority order
  localparam int NSRC = 5;
  localparam logic [2:0] SRC_LINE = 3'h0;
  localparam logic [2:0] SRC_RXDATA = 3'h1;
  localparam logic [2:0] SRC_RXTMO = 3'h2;
  localparam logic [2:0] SRC_TXEMPTY = 3'h3;
  localparam logic [2:0] SRC_MODEM = 3'h4;

  // Identity codes for the low nibble, and values for identity bits 5:4 and 7:6
  localparam logic [3:0] ID_LINE = 4'h6;
  localparam logic [3:0] ID_RXDATA = 4'h4;
  localparam logic [3:0] ID_RXTMO = 4'hc;
  localparam logic [3:0] ID_TXEMPTY = 4'h2;
  localparam logic [3:0] ID_MODEM = 4'h0;
  localparam logic [3:0] ID_NONE = 4'h1;
  localparam logic [1:0] ID_UNUSED = 2'h0;
  localparam logic [1:0] ID_FIFO_ON = 2'h3;
  localparam logic [1:0] ID_FIFO_OFF = 2'h0;

  // Line format control fields
  localparam int LFC_DLAB_BIT = 7;
  localparam int LFC_BRK_BIT = 6;
  localparam int LFC_PAR_MSB = 5;
  localparam int LFC_PAR_LSB = 3;
  localparam int LFC_STOP_BIT = 2;
  localparam int LFC_WLEN_MSB = 1;
  localparam int LFC_WLEN_LSB = 0;
  localparam logic [7:0] LFC_RESET = 8'h00;
  localparam logic [2:0] PAR_SEL_ODD = 3'h1;
  localparam logic [2:0] PAR_SEL_EVEN = 3'h3;
  localparam logic [2:0] PAR_SEL_FORCE1 = 3'h5;
  localparam logic [2:0] PAR_SEL_FORCE0 = 3'h7;
  localparam logic [3:0] WLEN_BASE = 4'h5;
  localparam logic [1:0] WLEN_FIVE = 2'h0;

  // Stop length in half bit times
  localparam logic [2:0] STOP_ONE = 3'h2;
  localparam logic [2:0] STOP_ONE_HALF = 3'h3;
  localparam logic [2:0] STOP_TWO = 3'h4;

  localparam int FIFO_EN_BIT = 0;
  localparam logic [4:0] MASK_RESET = 5'h00;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  typedef enum logic [2:0] {
    PAR_NONE = 3'h0,
    PAR_ODD = 3'h1,
    PAR_EVEN = 3'h2,
    PAR_FORCE1 = 3'h3,
    PAR_FORCE0 = 3'h4
  } uirq_par_t;

  // Gray path: idle -> hold -> idle
  typedef enum logic {
    RPT_IDLE = 1'b0,
    RPT_HOLD = 1'b1
  } uirq_rpt_t;

endpackage

// File: verilog/uirq_top.sv
// Per-channel interrupt identity and line format control of a UART, APB slave.
// Assumes event inputs are single-cycle pulses from logic on i_clk_sys.
// Behaviour
// [R01] Four priority levels; identity read shows code of highest pending source.
// [R02] A reported interrupt is not replaced by another until it is serviced.
// [R03] Identity read clears only the reported source; lower ones show on reread.
// [R04] Line status condition: level 1, code 0110.
// [R05] Received data available: level 2, code 0100.
// [R06] Receive timeout: level 2, code 1100, differs from data by bit 3.
// [R07] Transmit holding empty: level 3, code 0010.
// [R08] Modem status change: level 4, code 0000.
// [R09] Identity bits 7:6 read 11 in FIFO mode, 00 otherwise and by default.
// [R10] Identity bits 5:4 always read zero.
// [R11] Identity bit 0 is 0 while pending, 1 when none, 1 after reset.
// [R12] Format bit 7 enables divisor latch access; clear after reset.
// [R13] Format bit 6 holds serial output low as break until cleared.
// [R14] Format bits 5:3 select none, odd, even or forced-zero parity.
// [R15] Format bit 2 gives one, one and a half or two stop bits.
// [R16] Format bits 1:0 give five to eight data bits; default five.
// [R17] FIFO enable bit selects FIFO mode and drives identity bits 7:6.
// [R18] Pattern 101 selects parity forced to one.
// [R19] Line format control resets to all zeros.
//
// Implementation choices: the placing of the registers and the APB slave port.
module uirq_top #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Interrupt source events
  input wire logic i_line_condition_status_evt,
  input wire logic i_rx_data_available_evt,
  input wire logic i_rx_timeout_evt,
  input wire logic i_tx_holding_empty_evt,
  input wire logic i_modem_change_status_evt,
  // Serial transmit path
  input wire logic i_tx_serial,
  output logic o_tx_line,
  // Line format to transmitter and receiver
  output logic o_divisor_access,
  output logic [3:0] o_word_bits,
  output logic [2:0] o_stop_halves,
  output uirq_pkg::uirq_par_t o_parity_mode,
  output logic o_fifo_en,
  // Interrupt
  output logic o_irq
);
  import uirq_pkg::*;

  logic [NSRC-1:0] evt;
  logic [NSRC-1:0] pend_q, pend_d, clr_vec;
  logic [NSRC-1:0] stat_q, mask_q;
  logic [7:0] lfc_q;
  logic fifo_en_q;
  uirq_rpt_t rpt_q;
  logic [2:0] cur_q, top_src;
  logic [3:0] cur_code;
  logic [7:0] ident;
  logic setup, acc_wr, acc_rd, hit;
  logic [7:0] offs;
  logic rd_clr_ok_q, id_clr;
  logic [31:0] rd_val;

  assign evt = {i_modem_change_status_evt, i_tx_holding_empty_evt, i_rx_timeout_evt,
                i_rx_data_available_evt, i_line_condition_status_evt};

  // Bus decode; zero wait states, so the access phase always completes
  assign offs = 8'(i_paddr);
  assign setup = i_psel && !i_penable;
  assign acc_wr = i_psel && i_penable && i_pwrite;
  assign acc_rd = i_psel && i_penable && !i_pwrite;
  assign o_pready = 1'b1;
  assign hit = (offs == OFS_IDENT) || (offs == OFS_LFC) || (offs == OFS_FIFO) ||
               (offs == OFS_EVT_STAT) || (offs == OFS_EVT_MASK);

  // Highest-priority pending source, lowest index wins
  always_comb begin
    top_src = SRC_MODEM;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (pend_q[i]) begin
        top_src = 3'(i);
      end
    end
  end

  always_comb begin
    case (cur_q)
      SRC_LINE: cur_code = ID_LINE; // R04
      SRC_RXDATA: cur_code = ID_RXDATA; // R05
      SRC_RXTMO: cur_code = ID_RXTMO; // R06
      SRC_TXEMPTY: cur_code = ID_TXEMPTY; // R07
      default: cur_code = ID_MODEM; // R08
    endcase
  end

  // R09 R10 R11
  assign ident = {(fifo_en_q ? ID_FIFO_ON : ID_FIFO_OFF), ID_UNUSED,
                  (rpt_q == RPT_HOLD) ? cur_code : ID_NONE};

  // The clear only acts if the read, sampled at setup, saw a reported source
  assign id_clr = acc_rd && (offs == OFS_IDENT) && rd_clr_ok_q;

  always_comb begin
    clr_vec = '0;
    if (id_clr) begin
      clr_vec[cur_q] = 1'b1; // R03
    end
  end

  // Masked events latch as pending; a same-cycle event beats the read clear
  assign pend_d = (pend_q & ~clr_vec) | (evt & mask_q);

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      pend_q <= '0;
    end else begin
      pend_q <= pend_d;
    end
  end

  // Reporting latch: frozen while a source is reported and unserviced
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      rpt_q <= RPT_IDLE;
      cur_q <= SRC_LINE;
    end else begin
      case (rpt_q)
        RPT_IDLE: begin
          if (|pend_q) begin
            rpt_q <= RPT_HOLD; // R01
            cur_q <= top_src; // R01
          end
        end
        RPT_HOLD: begin
          if (id_clr) begin
            rpt_q <= RPT_IDLE; // R02
          end
        end
        default: rpt_q <= RPT_IDLE;
      endcase
    end
  end

  // Line format control register
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      lfc_q <= LFC_RESET; // R19
    end else if (acc_wr && (offs == OFS_LFC) && i_pstrb[0]) begin
      lfc_q <= i_pwdata[7:0];
    end
  end

  // FIFO setup control, only the enable bit lives here
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      fifo_en_q <= 1'b0;
    end else if (acc_wr && (offs == OFS_FIFO) && i_pstrb[0]) begin
      fifo_en_q <= i_pwdata[FIFO_EN_BIT]; // R17
    end
  end

  // Sticky event status, write one to clear; set wins over clear
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      stat_q <= '0;
    end else if (acc_wr && (offs == OFS_EVT_STAT) && i_pstrb[0]) begin
      stat_q <= (stat_q & ~i_pwdata[NSRC-1:0]) | evt;
    end else begin
      stat_q <= stat_q | evt;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      mask_q <= MASK_RESET;
    end else if (acc_wr && (offs == OFS_EVT_MASK) && i_pstrb[0]) begin
      mask_q <= i_pwdata[NSRC-1:0];
    end
  end

  assign o_irq = |(stat_q & mask_q);

  // Read data is captured in the setup cycle, so it comes from flops
  always_comb begin
    case (offs)
      OFS_IDENT: rd_val = {24'h00_0000, ident};
      OFS_LFC: rd_val = {24'h00_0000, lfc_q};
      OFS_FIFO: rd_val = {31'h0000_0000, fifo_en_q};
      OFS_EVT_STAT: rd_val = {27'h000_0000, stat_q};
      OFS_EVT_MASK: rd_val = {27'h000_0000, mask_q};
      default: rd_val = RD_ZERO;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_prdata <= RD_ZERO;
      o_pslverr <= 1'b0;
      rd_clr_ok_q <= 1'b0;
    end else if (setup) begin
      o_prdata <= i_pwrite ? RD_ZERO : rd_val;
      o_pslverr <= !hit;
      rd_clr_ok_q <= (rpt_q == RPT_HOLD);
    end
  end

  // Decoded format, registered toward the serial engines
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_tx_line <= 1'b1;
      o_divisor_access <= 1'b0;
      o_word_bits <= WLEN_BASE;
      o_stop_halves <= STOP_ONE;
      o_parity_mode <= PAR_NONE;
      o_fifo_en <= 1'b0;
    end else begin
      o_tx_line <= i_tx_serial && !lfc_q[LFC_BRK_BIT]; // R13
      o_divisor_access <= lfc_q[LFC_DLAB_BIT]; // R12
      o_word_bits <= WLEN_BASE + 4'(lfc_q[LFC_WLEN_MSB:LFC_WLEN_LSB]); // R16
      if (!lfc_q[LFC_STOP_BIT]) begin
        o_stop_halves <= STOP_ONE; // R15
      end else if (lfc_q[LFC_WLEN_MSB:LFC_WLEN_LSB] == WLEN_FIVE) begin
        o_stop_halves <= STOP_ONE_HALF; // R15
      end else begin
        o_stop_halves <= STOP_TWO; // R15
      end
      case (lfc_q[LFC_PAR_MSB:LFC_PAR_LSB])
        PAR_SEL_ODD: o_parity_mode <= PAR_ODD; // R14
        PAR_SEL_EVEN: o_parity_mode <= PAR_EVEN; // R14
        PAR_SEL_FORCE1: o_parity_mode <= PAR_FORCE1; // R18
        PAR_SEL_FORCE0: o_parity_mode <= PAR_FORCE0; // R14
        default: o_parity_mode <= PAR_NONE; // R14
      endcase
      o_fifo_en <= fifo_en_q;
    end
  end

  // Checks
  sequence s_id_read_clear;
    id_clr && !evt[cur_q];
  endsequence

  sequence s_pick;
    (rpt_q == RPT_IDLE) && (|pend_q);
  endsequence

  a_pick_highest: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R01
    s_pick |=> (rpt_q == RPT_HOLD) && (cur_q == $past(top_src)) &&
      !(|($past(pend_q) & ((5'h01 << cur_q) - 5'h01))))
    else $error("reported source is not the highest pending");

  a_hold_stable: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R02
    (rpt_q == RPT_HOLD) && !id_clr |=> (rpt_q == RPT_HOLD) && $stable(cur_q))
    else $error("reported source changed before service");

  a_read_clears: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R03
    s_id_read_clear |=> !pend_q[$past(cur_q)] &&
      (((pend_q | $past(pend_q)) & ~(5'h01 << $past(cur_q))) ==
       (pend_q & ~(5'h01 << $past(cur_q)))))
    else $error("identity read did not clear exactly the reported source");

  a_line_code: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R04
    (rpt_q == RPT_HOLD) && (cur_q == SRC_LINE) |-> ident[3:0] == 4'h6)
    else $error("line condition code wrong");

  a_level2_codes: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R05
    (rpt_q == RPT_HOLD) && (cur_q == SRC_RXDATA) |-> ident[3:0] == 4'h4)
    else $error("received data code wrong");

  a_timeout_code: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R06
    (rpt_q == RPT_HOLD) && (cur_q == SRC_RXTMO) |-> ident[3:0] == 4'hc)
    else $error("timeout code wrong");

  a_low_codes: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R07
    (rpt_q == RPT_HOLD) && (cur_q == SRC_TXEMPTY) |-> ident[3:0] == 4'h2)
    else $error("transmit empty code wrong");

  a_modem_code: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R08
    (rpt_q == RPT_HOLD) && (cur_q == SRC_MODEM) |-> ident[3:0] == 4'h0)
    else $error("modem change code wrong");

  a_fifo_bits: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R09
    ident[7:6] == (o_fifo_en ? 2'b11 : 2'b00) || $changed(fifo_en_q))
    else $error("fifo indication bits disagree with fifo mode");

  a_unused_zero: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R10
    ident[5:4] == 2'b00)
    else $error("unused identity bits not zero");

  a_none_bit: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R11
    (|pend_q) && (rpt_q == RPT_IDLE) |=> !ident[0])
    else $error("pending interrupt not shown in bit 0");

  a_break_line: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R13
    lfc_q[LFC_BRK_BIT] [*2] |-> !o_tx_line)
    else $error("break not holding line low");

  a_stop_len: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R15
    $stable(lfc_q) |-> o_stop_halves ==
      (!lfc_q[2] ? 3'h2 : (lfc_q[1:0] == 2'b00) ? 3'h3 : 3'h4))
    else $error("stop length wrong");

  a_format_reset: assert property (@(posedge i_clk_sys) // R19
    i_rst |=> lfc_q == 8'h00 && o_word_bits == 4'h5 && !o_divisor_access)
    else $error("line format not cleared by reset");

endmodule

// File: tb/uirq_host.sv
// Host processor model: an APB master that runs one transfer per call.
// Assumes the slave may add wait states; only the bench timeout ends a wait.
module uirq_host (
  // Clock
  input wire logic i_clk_sys,
  // Slave answer
  input wire logic i_pready,
  input wire logic [31:0] i_prdata,
  input wire logic i_pslverr,
  // Request
  output logic o_psel,
  output logic o_penable,
  output logic o_pwrite,
  output logic [7:0] o_paddr,
  output logic [31:0] o_pwdata,
  output logic [3:0] o_pstrb
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = 8'h00;
    o_pwdata = 32'h0000_0000;
    o_pstrb = 4'hf;
  end

  // Request is held until pready is seen high at a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge i_clk_sys);
    o_psel <= 1'b1;
    o_penable <= 1'b0;
    o_pwrite <= w;
    o_paddr <= a;
    o_pwdata <= d;
    @(posedge i_clk_sys);
    o_penable <= 1'b1;
    @(posedge i_clk_sys);
    while (i_pready !== 1'b1) @(posedge i_clk_sys);
    r = i_prdata;
    e = i_pslverr;
    o_psel <= 1'b0;
    o_penable <= 1'b0;
  endtask
endmodule

// File: tb/uirq_top_test.sv
// Self-checking bench for the interrupt identity and line format block.
// Assumes the host model drives APB and the bench pulses the event inputs.
module uirq_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import uirq_pkg::*;

  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic i_tx_serial = 1'b1;
  logic [4:0] evt = 5'h00;
  logic psel, penable, pwrite, pready, pslverr, o_tx_line, o_divisor_access, o_fifo_en, o_irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, seed = 32'h0001_7a9d;
  logic [3:0] pstrb, o_word_bits;
  logic [2:0] o_stop_halves;
  uirq_par_t o_parity_mode;
  int failures = 0;
  int n_tests = 0;
  int cyc = 0;

  always #12.5 i_clk_sys = ~i_clk_sys;

  uirq_host host (.i_clk_sys(i_clk_sys), .i_pready(pready), .i_prdata(prdata),
    .i_pslverr(pslverr), .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite),
    .o_paddr(paddr), .o_pwdata(pwdata), .o_pstrb(pstrb));

  uirq_top dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_line_condition_status_evt(evt[0]), .i_rx_data_available_evt(evt[1]),
    .i_rx_timeout_evt(evt[2]), .i_tx_holding_empty_evt(evt[3]),
    .i_modem_change_status_evt(evt[4]), .i_tx_serial(i_tx_serial), .o_tx_line(o_tx_line),
    .o_divisor_access(o_divisor_access), .o_word_bits(o_word_bits),
    .o_stop_halves(o_stop_halves), .o_parity_mode(o_parity_mode), .o_fifo_en(o_fifo_en),
    .o_irq(o_irq));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [2:0] exp_stop(input logic [7:0] v);
    if (!v[2]) return STOP_ONE;
    return (v[1:0] == WLEN_FIVE) ? STOP_ONE_HALF : STOP_TWO;
  endfunction

  function automatic uirq_par_t exp_par(input logic [7:0] v);
    if (!v[3]) return PAR_NONE;
    if (!v[4]) return v[5] ? PAR_FORCE1 : PAR_ODD;
    return v[5] ? PAR_FORCE0 : PAR_EVEN;
  endfunction

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Ceiling of 5000 cycles is about thirteen times the expected run length of some 385 cycles
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      tally_and_finish();
    end
  end

  task automatic chk(input string nm, input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    host.xfer(1'b1, a, d, r, e);
    repeat (2) @(posedge i_clk_sys);
    #1;
  endtask

  // Two idle edges let the next pending source reach the identity latch
  task automatic rdchk(input logic [7:0] a, input logic [31:0] x, input string nm);
    logic [31:0] r;
    logic e;
    host.xfer(1'b0, a, 32'h0, r, e);
    chk(nm, r, x);
    repeat (2) @(posedge i_clk_sys);
  endtask

  task automatic pulse(input logic [4:0] v);
    @(posedge i_clk_sys);
    evt <= v;
    @(posedge i_clk_sys);
    evt <= 5'h00;
    repeat (3) @(posedge i_clk_sys);
    #1;
  endtask

  initial begin
    logic [31:0] v, r;
    logic e;
    repeat (2) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    #1;
    chk("word_bits", 32'(o_word_bits), 32'h5);
    chk("irq", 32'(o_irq), 32'h0);
    chk("pready", 32'(pready), 32'h1);
    rdchk(OFS_LFC, 32'h0, "line_format");
    rdchk(OFS_IDENT, 32'h1, "identity");
    $display("test reset done");
    for (int i = 0; i < 24; i++) begin
      v = xs();
      if (i < 8) v[5:3] = i[2:0];
      i_tx_serial <= v[8];
      wr(OFS_LFC, {24'h0, v[7:0]});
      chk("word_bits", 32'(o_word_bits), 32'(4'h5 + {2'h0, v[1:0]}));
      chk("stop", 32'(o_stop_halves), 32'(exp_stop(v[7:0])));
      chk("parity", 32'(o_parity_mode), 32'(exp_par(v[7:0])));
      chk("divisor", 32'(o_divisor_access), 32'(v[7]));
      chk("tx_line", 32'(o_tx_line), 32'(v[8] & ~v[6]));
      rdchk(OFS_LFC, {24'h0, v[7:0]}, "line_format");
    end
    wr(OFS_LFC, 32'h0);
    $display("test line format done");
    wr(OFS_EVT_MASK, 32'h1f);
    pulse(5'h1f);
    chk("irq", 32'(o_irq), 32'h1);
    rdchk(OFS_IDENT, 32'(ID_LINE), "identity");
    rdchk(OFS_IDENT, 32'(ID_RXDATA), "identity");
    rdchk(OFS_IDENT, 32'(ID_RXTMO), "identity");
    rdchk(OFS_IDENT, 32'(ID_TXEMPTY), "identity");
    rdchk(OFS_IDENT, 32'(ID_MODEM), "identity");
    rdchk(OFS_IDENT, 32'(ID_NONE), "identity");
    pulse(5'h10);
    pulse(5'h01);
    rdchk(OFS_IDENT, 32'(ID_MODEM), "identity");
    rdchk(OFS_IDENT, 32'(ID_LINE), "identity");
    $display("test priority done");
    rdchk(OFS_EVT_STAT, 32'h1f, "status");
    wr(OFS_EVT_STAT, 32'h1f);
    chk("irq", 32'(o_irq), 32'h0);
    wr(OFS_EVT_MASK, 32'h0);
    pulse(5'h02);
    chk("irq", 32'(o_irq), 32'h0);
    rdchk(OFS_IDENT, 32'(ID_NONE), "identity");
    rdchk(OFS_EVT_STAT, 32'h02, "status");
    wr(OFS_EVT_MASK, 32'h02);
    chk("irq", 32'(o_irq), 32'h1);
    wr(OFS_EVT_STAT, 32'h02);
    chk("irq", 32'(o_irq), 32'h0);
    $display("test interrupt done");
    wr(OFS_FIFO, 32'h1);
    chk("fifo_en", 32'(o_fifo_en), 32'h1);
    rdchk(OFS_IDENT, 32'hc1, "identity");
    wr(OFS_FIFO, 32'h0);
    wr(OFS_IDENT, 32'hff);
    rdchk(OFS_IDENT, 32'h01, "identity");
    host.xfer(1'b0, 8'h20, 32'h0, r, e);
    chk("slverr", 32'(e), 32'h1);
    chk("unmapped", r, 32'h0);
    $display("test fifo and map done");
    tally_and_finish();
  end
endmodule
